// [design/lcr_defs.vh]
// Constants for the link control register upper fields.
// Assumes inclusion by bare name from every design file of the block.
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH
`define LCR_ADDR_W        6
`define LCR_OFF_CTRL      6'h08
`define LCR_OFF_IRP       6'h20
`define LCR_OFF_STAT      6'h24
`define LCR_CTRL_RESET    32'h0000_0000
`define LCR_CTRL_WMASK    32'h83f3_ff80
`define LCR_B_BUSY        7
`define LCR_B_ON          8
`define LCR_B_RO          9
`define LCR_B_TXRST       10
`define LCR_B_RXRST       11
`define LCR_B_BLK_LO      12
`define LCR_B_BLK_HI      15
`define LCR_B_RC_LO       16
`define LCR_B_RC_HI       17
`define LCR_B_CYCLE_MASTER_ENABLE       20
`define LCR_B_CYCLE_SOURCE_EXTERNAL       21
`define LCR_B_CYCLE_TIMER_ENABLE       22
`define LCR_B_CYMRK       23
`define LCR_B_IRP1        24
`define LCR_B_IRP2        25
`define LCR_BCAST_NODE    6'h3f
`define LCR_RC_NEW        2'h0
`define LCR_RC_X          2'h1
`define LCR_RC_A          2'h2
`define LCR_RC_B          2'h3
`define LCR_BUSDEP_BASE   12'h200
`define LCR_BUSDEP_TOP    12'h400
`define LCR_BLOCK_BYTES   12'h080
`define LCR_OFFSET_MAX    12'hbff
`define LCR_CHAN_W        6
`define LCR_IRP1_LO       0
`define LCR_IRP1_HI       5
`define LCR_IRP2_LO       8
`define LCR_IRP2_HI       13
`define LCR_STAT_OFF_LO   0
`define LCR_STAT_OFF_HI   11
`define LCR_STAT_CNT_LO   13
`define LCR_STAT_CNT_HI   25
`endif

// [design/lcr_cycle_timer.v]
// Cycle timer: offset and count fields with internal or external source.
// Assumes the external cycle input is already synchronised to core_clk.
`include "lcr_defs.vh"
module lcr_cycle_timer #(
   parameter OFFSET_W = 12,
   parameter COUNT_W  = 13
) (
   input  wire                core_clk,
   input  wire                rst,
   input  wire                timer_enable,
   input  wire                source_external,
   input  wire                ext_cycle_rise,
   output reg  [OFFSET_W-1:0] cycle_offset,
   output reg  [COUNT_W-1:0]  cycle_count,
   output reg                 count_tick
);
   wire offset_wrap;
   assign offset_wrap = (cycle_offset == `LCR_OFFSET_MAX);

   // =======================================================================
   // Offset advances only with the timer enabled; count follows source.
   always @(posedge core_clk) begin
      if (rst) begin
         cycle_offset <= {OFFSET_W{1'b0}};
         cycle_count  <= {COUNT_W{1'b0}};
         count_tick   <= 1'b0;
      end else begin
         count_tick <= 1'b0;
         if (source_external) begin
            if (ext_cycle_rise) begin               // [R13]
               cycle_offset <= {OFFSET_W{1'b0}};
               cycle_count  <= cycle_count + 1'b1;
               count_tick   <= 1'b1;
            end else if (timer_enable) begin        // [R15]
               cycle_offset <= offset_wrap ? {OFFSET_W{1'b0}}
                                           : cycle_offset + 1'b1;
            end
         end else if (timer_enable) begin           // [R15]
            if (offset_wrap) begin                  // [R14]
               cycle_offset <= {OFFSET_W{1'b0}};
               cycle_count  <= cycle_count + 1'b1;
               count_tick   <= 1'b1;
            end else begin
               cycle_offset <= cycle_offset + 1'b1;
            end
         end
      end
   end
endmodule // lcr_cycle_timer

// [design/lcr_link_control.v]
// Upper fields of the link control register and the logic they steer.
// Holds the control word, the iso channel word and the timer status view,
// and turns their bits into request, iso, resend and cycle outputs.
// Assumes a plain register port on core_clk and a phy-side packet decoder
// that presents one request header per cycle with a valid strobe. The
// external cycle pulse is the only asynchronous input and is synchronised
// here; every other input already lives on core_clk.
//
// Overview of operation
// R1: Busy acknowledge when on, low region, busy, and write allowed or read.
// R2: With access on, busy and read-only bits decide low-region acceptance.
// R3: With physical access on, read-only refuses writes to the low region.
// R4: Transmit reset bit resets the whole transmitter and self-clears.
// R5: Receiver reset bit resets the receiver synchronously and self-clears.
// R6: Block field bit 0 drops broadcasts to lowest 128 bus-dependent bytes.
// R7: Block field bit 3 drops broadcasts to highest 128 bus-dependent bytes.
// R8: The last received retry code is held in a two-bit field.
// R9: On resend, the stored retry code is ORed into the packet code.
// R10: Retry codes: 00 new, 01 X, 10 A, 11 B.
// R11: Cycle master works only with its bit set and the node root.
// R12: As cycle master, send cycle start whenever cycle count increments.
// R13: External source: each input rise bumps count and clears offset.
// R14: Internal source: count increments when the offset rolls over.
// R15: The cycle offset advances only while the timer enable is set.
// R16: Cycle mark enable inserts a mark at each cycle end; else none.
// R17: Port one enabled accepts iso packets matching port one channel.
// R18: Port two enabled accepts iso packets matching port two channel.
// R19: Node 3Fh broadcasts are always accepted unless the block field drops; unblocked ones still pass the physical-region checks here.
// R20: Self-clearing reset bits read back zero the cycle after the pulse.
module lcr_link_control (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [5:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   input  wire        external_cycle_pulse,
   input  wire        phy_is_root,
   input  wire        req_valid,
   input  wire [5:0]  req_dest_node,
   input  wire        req_is_read,
   input  wire        req_is_physical,
   input  wire        req_offset_low4g,
   input  wire [11:0] req_csr_offset,
   input  wire        req_is_csr,
   input  wire        ack_retry_valid,
   input  wire [1:0]  ack_retry_code,
   input  wire        iso_valid,
   input  wire [5:0]  iso_channel,
   input  wire        tx_resend,
   input  wire [1:0]  tx_packet_retry,
   input  wire        iso_cycle_end,
   output reg         req_accept,
   output reg         req_busy_ack,
   output reg         req_drop,
   output reg         iso_accept,
   output reg  [1:0]  tx_retry_out,
   output reg         tx_soft_reset,
   output reg         rx_soft_reset,
   output reg         cycle_start_send,
   output reg         general_receive_buffer_mark,
   output reg  [12:0] cycle_count_out
);
`include "lcr_defs.vh"

   // =======================================================================
   // Control word layout, bit by bit; bits not listed read as zero.
   //   [7]      phys_region_busy: busy acknowledge for low-region requests.
   //   [8]      phys_region_on: physical-region filtering is active.
   //   [9]      phys_region_read_only: low-region writes are refused.
   //   [10]     transmitter_soft_reset: self-clearing, pulses tx_soft_reset.
   //   [11]     receiver_soft_reset: self-clearing, pulses rx_soft_reset.
   //   [15:12]  broadcast_block_field: bit 12 low block, bit 15 high block.
   //   [17:16]  async_tx_retry_code: last retry code seen on an ack.
   //   [20]     cycle_master_enable: cycle start on each count step while root.
   //   [21]     cycle_source_external: count follows the external pulse.
   //   [22]     cycle_timer_enable: lets the cycle offset run.
   //   [23]     cycle_mark_enable: marks into the general receive buffer.
   //   [24]     iso_rx_port_one_enable: channel match on port one.
   //   [25]     iso_rx_port_two_enable: channel match on port two.
   //   [31]     revision_a_enable: plain storage with no logic behind it.
   // Bits [6:0] belong to the lower control fields, which live outside this
   // block, so they read here as zero. Bits 18, 19 and 26 to 30 are reserved
   // and ignore writes.
   //
   // Channel word: port one channel in [5:0], port two channel in [13:8].
   // Timer status word: cycle count in [25:13], cycle offset in [11:0].
   // The timer status is read-only; writes to its address are ignored.

   localparam ISO_PORTS = 2;

   reg  [31:0] link_control;
   reg  [31:0] irp_word;
   reg  [31:0] stat_word;
   wire [1:0]  iso_port_hit;
   wire [11:0] iso_chan_bus;
   reg  [5:0]  iso_port_one_chan;
   reg  [5:0]  iso_port_two_chan;
   reg         ext_sync_a;
   reg         ext_sync_b;
   reg         ext_prev;
   wire        ext_rise;
   wire [11:0] cyc_offset;
   wire [12:0] cyc_count;
   wire        cyc_tick;
   wire        cycle_master_live;
   wire        phys_region_busy;
   wire        phys_region_on;
   wire        phys_region_read_only;
   wire [3:0]  broadcast_block_field;
   wire        is_broadcast;
   wire        bcast_blocked;

   assign phys_region_busy      = link_control[`LCR_B_BUSY];
   assign phys_region_on        = link_control[`LCR_B_ON];
   assign phys_region_read_only = link_control[`LCR_B_RO];
   assign broadcast_block_field =
      link_control[`LCR_B_BLK_HI:`LCR_B_BLK_LO];

   // Bus-dependent window test, shared by both block field bits.
   function in_window;
      input [11:0] off;
      input [11:0] base;
      begin
         in_window = (off >= base) && (off < base + `LCR_BLOCK_BYTES);
      end
   endfunction

   // =======================================================================
   // External cycle input: two flops, then an edge detector on the second.
   // All three flops reset low, the idle level of the pin, so leaving reset
   // never looks like a rising edge.
   always @(posedge core_clk) begin
      if (rst) begin
         ext_sync_a <= 1'b0;
         ext_sync_b <= 1'b0;
         ext_prev   <= 1'b0;
      end else begin
         ext_sync_a <= external_cycle_pulse;
         ext_sync_b <= ext_sync_a;
         ext_prev   <= ext_sync_b;
      end
   end
   assign ext_rise = ext_sync_b & ~ext_prev;

   lcr_cycle_timer #(
      .OFFSET_W (12),
      .COUNT_W  (13)
   ) u_timer (
      .core_clk        (core_clk),
      .rst             (rst),
      .timer_enable    (link_control[`LCR_B_CYCLE_TIMER_ENABLE]),
      .source_external (link_control[`LCR_B_CYCLE_SOURCE_EXTERNAL]),
      .ext_cycle_rise  (ext_rise),
      .cycle_offset    (cyc_offset),
      .cycle_count     (cyc_count),
      .count_tick      (cyc_tick)
   );

   // =======================================================================
   // Register file. Reset bits self-clear one cycle after being written,
   // so software never has to write them back to zero. Only bits inside the
   // write mask take software data. Software may write the retry code too,
   // but the next acknowledge that carries a code overwrites it.
   always @(posedge core_clk) begin
      if (rst) begin
         link_control      <= `LCR_CTRL_RESET;
         iso_port_one_chan <= 6'h00;
         iso_port_two_chan <= 6'h00;
      end else begin
         link_control[`LCR_B_TXRST] <= 1'b0;                    // [R4] [R20]
         link_control[`LCR_B_RXRST] <= 1'b0;                    // [R5] [R20]
         if (reg_write && reg_addr == `LCR_OFF_CTRL) begin
            link_control <= (reg_wdata & `LCR_CTRL_WMASK) |
                            (link_control & ~`LCR_CTRL_WMASK);
         end else if (reg_write && reg_addr == `LCR_OFF_IRP) begin
            iso_port_one_chan <= reg_wdata[`LCR_IRP1_HI:`LCR_IRP1_LO];
            iso_port_two_chan <= reg_wdata[`LCR_IRP2_HI:`LCR_IRP2_LO];
         end
         // Hardware update of the retry code wins over a software write.
         if (ack_retry_valid) begin
            link_control[`LCR_B_RC_HI:`LCR_B_RC_LO] <= ack_retry_code; // [R8]
         end
      end
   end

   // Readback words for the channel and timer registers, built field by
   // field so that every unused bit reads zero without hand-counted padding.
   always @* begin
      irp_word  = 32'h0000_0000;
      stat_word = 32'h0000_0000;
      irp_word[`LCR_IRP1_HI:`LCR_IRP1_LO] = iso_port_one_chan;
      irp_word[`LCR_IRP2_HI:`LCR_IRP2_LO] = iso_port_two_chan;
      stat_word[`LCR_STAT_OFF_HI:`LCR_STAT_OFF_LO] = cyc_offset;
      stat_word[`LCR_STAT_CNT_HI:`LCR_STAT_CNT_LO] = cyc_count;
   end

   // Read mux; unmapped addresses read zero.
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         if (reg_addr == `LCR_OFF_CTRL) begin
            reg_rdata <= link_control;
         end else if (reg_addr == `LCR_OFF_IRP) begin
            reg_rdata <= irp_word;
         end else if (reg_addr == `LCR_OFF_STAT) begin
            reg_rdata <= stat_word;
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end
   end

   // =======================================================================
   // Request filtering. A broadcast that the block field drops never reaches
   // the physical-region checks, so a blocked write cannot draw a busy ack.
   // The window test sees only the twelve offset bits; the decoder is trusted
   // to flag bus-dependent space through req_is_csr.
   assign is_broadcast = (req_dest_node == `LCR_BCAST_NODE);
   assign bcast_blocked = is_broadcast && req_is_csr &&
      ((broadcast_block_field[0] &&
        in_window(req_csr_offset, `LCR_BUSDEP_BASE)) ||               // [R6]
       (broadcast_block_field[3] &&
        in_window(req_csr_offset,
                  `LCR_BUSDEP_TOP - `LCR_BLOCK_BYTES)));              // [R7]

   always @(posedge core_clk) begin
      if (rst) begin
         req_accept   <= 1'b0;
         req_busy_ack <= 1'b0;
         req_drop     <= 1'b0;
      end else begin
         req_accept   <= 1'b0;
         req_busy_ack <= 1'b0;
         req_drop     <= 1'b0;
         if (req_valid) begin
            if (bcast_blocked) begin
               req_drop <= 1'b1;                                       // [R19]
            end else if (req_is_physical && req_offset_low4g &&
                         phys_region_on) begin                         // [R2]
               if (phys_region_read_only && !req_is_read) begin
                  req_drop <= 1'b1;                                    // [R3]
               end else if (phys_region_busy) begin
                  req_busy_ack <= 1'b1;                                // [R1]
               end else begin
                  req_accept <= 1'b1;
               end
            end else begin
               req_accept <= 1'b1;                                     // [R19]
            end
         end
      end
   end

   // =======================================================================
   // Iso channel match, one comparator per receive port. Port one owns the
   // lower enable bit and the lower channel field of each pair.
   assign iso_chan_bus = {iso_port_two_chan, iso_port_one_chan};
   genvar gp;
   generate                                                  // [R17] [R18]
      for (gp = 0; gp < ISO_PORTS; gp = gp + 1) begin : g_iso_port
         assign iso_port_hit[gp] = link_control[`LCR_B_IRP1 + gp] &&
            (iso_channel == iso_chan_bus[gp*`LCR_CHAN_W +: `LCR_CHAN_W]);
      end
   endgenerate

   // Iso accept, resend retry code, resets, cycle master and marks.
   always @(posedge core_clk) begin
      if (rst) begin
         iso_accept                  <= 1'b0;
         tx_retry_out                <= `LCR_RC_NEW;
         tx_soft_reset               <= 1'b0;
         rx_soft_reset               <= 1'b0;
         cycle_start_send            <= 1'b0;
         general_receive_buffer_mark <= 1'b0;
         cycle_count_out             <= 13'h0000;
      end else begin
         iso_accept <= iso_valid && (|iso_port_hit);             // [R17] [R18]
         // Codes follow 00 new, 01 X, 10 A, 11 B; OR keeps encoding. [R10]
         // The OR only works because software leaves the packet code at
         // zero; a nonzero code would merge with the stored one.
         if (tx_resend) begin
            tx_retry_out <= tx_packet_retry |
               link_control[`LCR_B_RC_HI:`LCR_B_RC_LO];                // [R9]
         end
         tx_soft_reset <= link_control[`LCR_B_TXRST];                  // [R4]
         rx_soft_reset <= link_control[`LCR_B_RXRST];                  // [R5]
         cycle_start_send <= cycle_master_live && cyc_tick;            // [R12]
         general_receive_buffer_mark <=
            link_control[`LCR_B_CYMRK] && iso_cycle_end;               // [R16]
         cycle_count_out <= cyc_count;
      end
   end
   // Cycle master needs both its enable and the root position; losing root
   // status stops cycle starts at the next count step without software help.
   assign cycle_master_live =
      link_control[`LCR_B_CYCLE_MASTER_ENABLE] && phy_is_root;                     // [R11]
endmodule // lcr_link_control

// [test/lcr_props.sv]
// =====================================================================
// Checker for the link control register upper fields.
// Assumes it is bound to lcr_link_control and sees only its ports.
module lcr_props (
   input wire        core_clk,
   input wire        rst,
   input wire [5:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_write,
   input wire        req_valid,
   input wire        phy_is_root,
   input wire        iso_valid,
   input wire        iso_cycle_end,
   input wire        req_accept,
   input wire        req_busy_ack,
   input wire        req_drop,
   input wire        iso_accept,
   input wire        tx_soft_reset,
   input wire        rx_soft_reset,
   input wire        cycle_start_send,
   input wire        general_receive_buffer_mark
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire ctl_wr = reg_write && (reg_addr == 6'h08);
   a_tx_reset_pulse: assert property (
      ctl_wr && reg_wdata[10] |-> ##2 tx_soft_reset)
      else $error("transmitter reset missing");
   a_rx_reset_pulse: assert property (
      ctl_wr && reg_wdata[11] |-> ##2 rx_soft_reset)
      else $error("receiver reset missing");
   a_reset_self_clear: assert property (
      tx_soft_reset |=> !tx_soft_reset)
      else $error("transmitter reset stuck");
   a_rx_self_clear: assert property (
      rx_soft_reset |=> !rx_soft_reset)
      else $error("receiver reset stuck");
   a_one_answer: assert property (
      req_valid |=> $onehot({req_accept, req_busy_ack, req_drop}))
      else $error("request answer not unique");
   a_no_stray_answer: assert property (
      !req_valid |=> !(req_accept || req_busy_ack || req_drop))
      else $error("answer without request");
   a_master_needs_root: assert property (
      cycle_start_send |-> $past(phy_is_root))
      else $error("cycle start while not root");
   a_mark_cause: assert property (
      general_receive_buffer_mark |-> $past(iso_cycle_end))
      else $error("mark without cycle end");
   a_iso_cause: assert property (
      iso_accept |-> $past(iso_valid))
      else $error("iso accept without packet");
   c_busy: cover property (req_busy_ack);
   c_start: cover property (cycle_start_send);
   c_tx_reset: cover property (tx_soft_reset);
endmodule // lcr_props

bind lcr_link_control lcr_props u_props (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .req_valid(req_valid), .phy_is_root(phy_is_root), .iso_valid(iso_valid),
   .iso_cycle_end(iso_cycle_end), .req_accept(req_accept),
   .req_busy_ack(req_busy_ack), .req_drop(req_drop), .iso_accept(iso_accept),
   .tx_soft_reset(tx_soft_reset), .rx_soft_reset(rx_soft_reset),
   .cycle_start_send(cycle_start_send),
   .general_receive_buffer_mark(general_receive_buffer_mark));

// [test/lcr_phy_model.sv]
// =====================================================================
// Phy-side model: presents one request header for each send command.
// Assumes commands change just after a rising core_clk edge.
module lcr_phy_model (
   input  wire        core_clk,
   input  wire        send,
   input  wire [21:0] hdr,
   output reg         req_valid,
   output reg  [21:0] req_hdr
);
   initial begin
      req_valid = 1'b0;
      req_hdr   = 22'h0;
   end
   // Idle fields toggle, so sampling outside the valid pulse sees junk.
   always @(posedge core_clk) begin
      req_valid <= send;
      req_hdr   <= send ? hdr : ~req_hdr;
   end
endmodule // lcr_phy_model

// [test/testbench.sv]
// =====================================================================
// Self-checking bench for the link control register upper fields.
// Assumes the checker and phy model are compiled before this file.
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 0, rst = 1, reg_write = 0, reg_read = 0, send = 0;
   logic        ack_retry_valid = 0, iso_valid = 0, tx_resend = 0;
   logic        iso_cycle_end = 0, external_cycle_pulse = 0, phy_is_root = 0;
   logic [5:0]  reg_addr = 0, iso_channel = 0;
   logic [31:0] reg_wdata = 0;
   logic [21:0] hdr = 0;
   logic [1:0]  ack_retry_code = 0, tx_packet_retry = 0;
   wire  [31:0] reg_rdata;
   wire  [21:0] req_hdr;
   wire  [1:0]  tx_retry_out;
   wire  [12:0] cycle_count_out;
   wire         req_valid, req_accept, req_busy_ack, req_drop, iso_accept;
   wire         tx_soft_reset, rx_soft_reset, cycle_start_send, mark;
   int          compares = 0, miscompares = 0, i;
   logic [40:0] rows [11];
   logic [19:0] iso_rows [4];
   always #50 core_clk = ~core_clk;
   lcr_phy_model phy (.core_clk(core_clk), .send(send), .hdr(hdr),
      .req_valid(req_valid), .req_hdr(req_hdr));
   lcr_link_control dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .external_cycle_pulse(external_cycle_pulse),
      .phy_is_root(phy_is_root), .req_valid(req_valid),
      .req_dest_node(req_hdr[21:16]), .req_is_read(req_hdr[15]),
      .req_is_physical(req_hdr[14]), .req_offset_low4g(req_hdr[13]),
      .req_is_csr(req_hdr[12]), .req_csr_offset(req_hdr[11:0]),
      .ack_retry_valid(ack_retry_valid), .ack_retry_code(ack_retry_code),
      .iso_valid(iso_valid), .iso_channel(iso_channel), .tx_resend(tx_resend),
      .tx_packet_retry(tx_packet_retry), .iso_cycle_end(iso_cycle_end),
      .req_accept(req_accept), .req_busy_ack(req_busy_ack),
      .req_drop(req_drop), .iso_accept(iso_accept),
      .tx_retry_out(tx_retry_out), .tx_soft_reset(tx_soft_reset),
      .rx_soft_reset(rx_soft_reset), .cycle_start_send(cycle_start_send),
      .general_receive_buffer_mark(mark), .cycle_count_out(cycle_count_out));
   // Bus tasks: strobes last one cycle and change just after an edge.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   task automatic end_sim;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      // Rows: control low half, header, expected {accept, busy, drop}.
      rows = '{{16'h0100, 6'h01, 4'b0110, 12'h0, 3'b100},
         {16'h0180, 6'h01, 4'b0110, 12'h0, 3'b010},
         {16'h0380, 6'h01, 4'b0110, 12'h0, 3'b001},
         {16'h0380, 6'h01, 4'b1110, 12'h0, 3'b010},
         {16'h0300, 6'h01, 4'b1110, 12'h0, 3'b100},
         {16'h0180, 6'h01, 4'b0100, 12'h0, 3'b100},
         {16'h0080, 6'h01, 4'b0110, 12'h0, 3'b100},
         {16'h1000, 6'h3f, 4'b0001, 12'h27f, 3'b001},
         {16'h1000, 6'h3f, 4'b0001, 12'h280, 3'b100},
         {16'h8000, 6'h3f, 4'b0001, 12'h380, 3'b001},
         {16'h8000, 6'h3f, 4'b0001, 12'h37f, 3'b100}};
      iso_rows = '{{12'h010, 6'h05, 2'b10}, {12'h010, 6'h0a, 2'b00},
         {12'h028, 6'h0a, 2'b11}, {12'h028, 6'h05, 2'b01}};
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(6'h08, 32'h0);
      rd(6'h24, 32'h0);
      wr(6'h08, 32'hffff_ffff);
      rd(6'h08, 32'h83f3_f380);
      rd(6'h3c, 32'h0);
      $display("test registers done");
      for (i = 0; i < 11; i++) begin
         wr(6'h08, {16'h0, rows[i][40:25]});
         @(posedge core_clk);
         send <= 1'b1;
         hdr  <= rows[i][24:3];
         @(posedge core_clk);
         send <= 1'b0;
         @(posedge core_clk);
         #1 `CHK({req_accept, req_busy_ack, req_drop}, rows[i][2:0])
      end
      $display("test requests done");
      wr(6'h08, 32'h0);
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk);
         ack_retry_valid <= 1'b1;
         ack_retry_code  <= i[1:0];
         @(posedge core_clk);
         ack_retry_valid <= 1'b0;
         rd(6'h08, {14'h0, i[1:0], 16'h0});
         @(posedge core_clk);
         tx_resend <= 1'b1;
         @(posedge core_clk);
         tx_resend <= 1'b0;
         @(posedge core_clk);
         #1 `CHK(tx_retry_out, i[1:0])
      end
      $display("test retry done");
      wr(6'h20, 32'h0000_0a05);
      for (i = 0; i < 4; i++) begin
         wr(6'h08, {iso_rows[i][19:8], 20'h0});
         @(posedge core_clk);
         iso_valid     <= 1'b1;
         iso_cycle_end <= 1'b1;
         iso_channel   <= iso_rows[i][7:2];
         @(posedge core_clk);
         iso_valid     <= 1'b0;
         iso_cycle_end <= 1'b0;
         #1 `CHK({iso_accept, mark}, iso_rows[i][1:0])
      end
      $display("test iso done");
      wr(6'h08, 32'h0050_0000);
      phy_is_root <= 1'b1;
      for (i = 0; i < 3200 && cycle_start_send !== 1'b1; i++)
         @(posedge core_clk) #1;
      `CHK(cycle_start_send, 1'b1)
      if (i == 3200)
         end_sim();
      `CHK(cycle_count_out, 13'h1)
      wr(6'h08, 32'h0070_0000);
      external_cycle_pulse <= 1'b1;
      repeat (4) @(posedge core_clk);
      external_cycle_pulse <= 1'b0;
      for (i = 0; i < 10 && cycle_count_out !== 13'h2; i++)
         @(posedge core_clk) #1;
      `CHK(cycle_count_out, 13'h2)
      $display("test cycle timer done");
      wr(6'h08, 32'h0000_0c00);
      @(posedge core_clk);
      #1 `CHK({tx_soft_reset, rx_soft_reset}, 2'b11)
      @(posedge core_clk);
      #1 `CHK({tx_soft_reset, rx_soft_reset}, 2'b00)
      $display("test soft resets done");
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(6'h08, 32'h0);
      rd(6'h24, 32'h0);
      $display("test reset done");
      end_sim();
   end
endmodule // testbench
